// *** verilog/gpo_mux_status_map.vh ***
/*
  register offsets, field positions, widths and reset values for the
  output-select, exact-frequency and status register group.
  assumes a register-access port that presents a 6-bit register index.
*/
`ifndef GPO_MUX_STATUS_MAP_VH
`define GPO_MUX_STATUS_MAP_VH

`define ADDR_W 6
`define DATA_W 24
`define OFF_EXACT_FREQ 6'h0c
`define OFF_OUT_SELECT 6'h0f
`define OFF_RSVD_A 6'h10
`define OFF_RSVD_B 6'h11
`define OFF_OUT_STATUS 6'h12
`define OFF_SELF_TEST 6'h13

`define EXACT_W 14
`define EXACT_RST 14'h0000
`define EXACT_MIN 14'h0002
`define SEL_W 10
`define SEL_RST 10'h001
`define SEL_LO 0
`define SEL_HI 4
`define SEL_TESTBIT 5
`define SEL_NOAUTOMUX 6
`define SEL_KEEPDRV 7
`define SRC_COUNT 32
`define SRC_TESTDATA 5'h00
`define SRC_LOCK 5'h01
`define SRC_LOCK_TRIG 5'h02
`define SRC_LOCK_WIN 5'h03
`define SRC_RING 5'h04
`define SRC_SLIP_A 5'h05
`define SRC_SLIP_B 5'h06
`define SRC_REF_BUF 5'h08
`define SRC_REF_DIV 5'h09
`define SRC_FB_DIV 5'h0a
`define SRC_MOD_CLK 5'h0b
`define SRC_AUX_CLK 5'h0c
`define SRC_AUX_SCLK 5'h0d
`define SRC_AUX_EN 5'h0e
`define SRC_AUX_DOUT 5'h0f
`define SRC_PHASE_DN 5'h10
`define SRC_PHASE_UP 5'h11
`define SRC_MOD_DLY 5'h12
`define SRC_MOD_CORE 5'h13
`define SRC_STB_INT 5'h14
`define SRC_STB_FRAC 5'h15
`define SRC_STB_AUX 5'h16
`define SRC_LATCH 5'h17
`define SRC_DIV_SYNC 5'h18
`define SRC_SEED 5'h19
`define SRC_BUF_EN 5'h1e
`define SRC_SOFT_RST 5'h1f
`define SEL_CODE_W 5
`define SYNC_DEPTH 2
`define ASYNC_N 2
`define ASYNC_LOCK 0
`define ASYNC_RING 1
`define SIG_W 16
`define ZERO_DATA 24'h00_0000
`define STATUS_PAD 22'h00_0000
`define TEST_PAD 7'h00

`endif

// *** verilog/gpo_mux_status_regs.v ***
/*
  output-select mux, exact-frequency channel count and read-only status
  registers of a fractional-n synthesizer register map.
  assumes a serial front end that decodes frames into a one-cycle write
  strobe or read strobe with a register index, all on clk; internal
  sources come from other clk-domain logic, except lockIn and ringOscIn
  which are asynchronous and are synchronised here.
*/
// Summary of operation
// - counts 0 and 1 disable exact mode
// - exact mode gives zero error at multiples
// - 5-bit select drives data-out, resets lock
// - codes 0 to 25 route listed sources, 7 unused
// - 26-29 unused; 30 buffer enable, 31 reset
// - select zero drives test-data bit
// - bit 6 stops lock auto-mux on data-out
// - bit 7 keeps data-out driver enabled
// - status reads output value and lock
// - self-test signature readable, 16 bits
// - self-test busy at bit 16, read live from selfTestRunning
// - 9-bit reserved reads zero, ignores writes
// - 19-bit reserved reads zero, ignores writes
`include "gpo_mux_status_map.vh"

module gpo_mux_status_regs (
  input wire clk,
  input wire rst_b,
  input wire wrStrobe,
  input wire rdStrobe,
  input wire [`ADDR_W-1:0] regAddr,
  input wire [`DATA_W-1:0] wrData,
  output wire [`DATA_W-1:0] rdData,
  output wire rdValid,
  input wire variantMode,
  input wire serialFrameActive,
  input wire serialDataOut,
  input wire lockIn,
  input wire lockTrigger,
  input wire lockWindow,
  input wire ringOscIn,
  input wire cycleSlipGuard,
  input wire refBufferOut,
  input wire refDividerOut,
  input wire feedbackDividerOut,
  input wire modulatorClock,
  input wire auxClock,
  input wire auxSerialClock,
  input wire auxSerialEnable,
  input wire auxSerialDataOut,
  input wire phaseDownPulse,
  input wire phaseUpPulse,
  input wire modDelayedClock,
  input wire modCoreClock,
  input wire autoStrobeInt,
  input wire autoStrobeFrac,
  input wire autoStrobeAux,
  input wire serialLatchEnable,
  input wire dividerSyncReset,
  input wire seedLoadStrobe,
  input wire serialBufferEnable,
  input wire softwareResetRequest,
  input wire [`SIG_W-1:0] selfTestSignature,
  input wire selfTestRunning,
  output wire [`EXACT_W-1:0] exactChannels,
  output wire exactEnable,
  output wire sdoOut,
  output wire sdoOe,
  output wire outputStatus
);

  reg [`EXACT_W-1:0] exactChannels_reg;
  reg [`EXACT_W-1:0] exactChannels_next;
  reg [`SEL_W-1:0] outSelect_reg;
  reg [`SEL_W-1:0] outSelect_next;
  reg [`EXACT_W-1:0] exactOut_reg;
  reg [`EXACT_W-1:0] exactOut_next;
  reg exactEnable_reg;
  reg exactEnable_next;
  reg sdoOut_reg;
  reg sdoOut_next;
  reg sdoOe_reg;
  reg sdoOe_next;
  reg outputStatus_reg;
  reg outputStatus_next;
  reg [`DATA_W-1:0] rdData_reg;
  reg [`DATA_W-1:0] rdData_next;
  reg rdValid_reg;
  reg rdValid_next;
  reg muxOut;
  wire [`ASYNC_N-1:0] asyncIn;
  wire [`ASYNC_N-1:0] asyncSync;
  wire [`SEL_CODE_W-1:0] srcSel;
  wire lockLive;
  wire ringLive;
  wire writeExact;
  wire writeSelect;
  genvar g;

  // index compare shared by write and read decode
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  assign asyncIn[`ASYNC_LOCK] = lockIn;
  assign asyncIn[`ASYNC_RING] = ringOscIn;
  assign lockLive = asyncSync[`ASYNC_LOCK];
  assign ringLive = asyncSync[`ASYNC_RING];
  assign srcSel = outSelect_reg[`SEL_HI:`SEL_LO];
  assign writeExact = wrStrobe && hit(regAddr, `OFF_EXACT_FREQ);
  assign writeSelect = wrStrobe && hit(regAddr, `OFF_OUT_SELECT);

  assign exactChannels = exactOut_reg;
  assign exactEnable = exactEnable_reg;
  assign sdoOut = sdoOut_reg;
  assign sdoOe = sdoOe_reg;
  assign outputStatus = outputStatus_reg;
  assign rdData = rdData_reg;
  assign rdValid = rdValid_reg;

  // two flops before any logic reads an asynchronous input; only the
  // last stage is read, the first may still be settling
  generate
    for (g = 0; g < `ASYNC_N; g = g + 1) begin : syncStage
      reg [`SYNC_DEPTH-1:0] stage_reg;
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          stage_reg <= {`SYNC_DEPTH{1'b0}};
        end else begin
          stage_reg <= {stage_reg[`SYNC_DEPTH-2:0], asyncIn[g]};
        end
      end
      assign asyncSync[g] = stage_reg[`SYNC_DEPTH-1];
    end
  endgenerate

  // writes to reserved and read-only indices match neither strobe and drop
  always @* begin
    exactChannels_next = exactChannels_reg;
    outSelect_next = outSelect_reg;
    if (writeExact) begin
      exactChannels_next = wrData[`EXACT_W-1:0];
    end
    if (writeSelect) begin
      outSelect_next = wrData[`SEL_W-1:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exactChannels_reg <= `EXACT_RST;
      outSelect_reg <= `SEL_RST;
    end else begin
      exactChannels_reg <= exactChannels_next;
      outSelect_reg <= outSelect_next;
    end
  end

  // source table; codes 7 and 26 to 29 have no source and give 0
  always @* begin
    case (srcSel)
      `SRC_TESTDATA: begin
        muxOut = outSelect_reg[`SEL_TESTBIT];
      end
      `SRC_LOCK: begin
        muxOut = lockLive;
      end
      `SRC_LOCK_TRIG: begin
        muxOut = lockTrigger;
      end
      `SRC_LOCK_WIN: begin
        muxOut = lockWindow;
      end
      `SRC_RING: begin
        muxOut = ringLive;
      end
      `SRC_SLIP_A: begin
        muxOut = cycleSlipGuard;
      end
      `SRC_SLIP_B: begin
        muxOut = cycleSlipGuard;
      end
      `SRC_REF_BUF: begin
        muxOut = refBufferOut;
      end
      `SRC_REF_DIV: begin
        muxOut = refDividerOut;
      end
      `SRC_FB_DIV: begin
        muxOut = feedbackDividerOut;
      end
      `SRC_MOD_CLK: begin
        muxOut = modulatorClock;
      end
      `SRC_AUX_CLK: begin
        muxOut = auxClock;
      end
      `SRC_AUX_SCLK: begin
        muxOut = auxSerialClock;
      end
      `SRC_AUX_EN: begin
        muxOut = auxSerialEnable;
      end
      `SRC_AUX_DOUT: begin
        muxOut = auxSerialDataOut;
      end
      `SRC_PHASE_DN: begin
        muxOut = phaseDownPulse;
      end
      `SRC_PHASE_UP: begin
        muxOut = phaseUpPulse;
      end
      `SRC_MOD_DLY: begin
        muxOut = modDelayedClock;
      end
      `SRC_MOD_CORE: begin
        muxOut = modCoreClock;
      end
      `SRC_STB_INT: begin
        muxOut = autoStrobeInt;
      end
      `SRC_STB_FRAC: begin
        muxOut = autoStrobeFrac;
      end
      `SRC_STB_AUX: begin
        muxOut = autoStrobeAux;
      end
      `SRC_LATCH: begin
        muxOut = serialLatchEnable;
      end
      `SRC_DIV_SYNC: begin
        muxOut = dividerSyncReset;
      end
      `SRC_SEED: begin
        muxOut = seedLoadStrobe;
      end
      `SRC_BUF_EN: begin
        muxOut = serialBufferEnable;
      end
      `SRC_SOFT_RST: begin
        muxOut = softwareResetRequest;
      end
      default: begin
        muxOut = 1'b0;
      end
    endcase
  end

  // fast sources are resampled at clk, so edges narrower than a period
  // can be missed on the pin
  always @* begin
    outputStatus_next = muxOut;
    if (serialFrameActive) begin
      sdoOut_next = serialDataOut;
    end else if (outSelect_reg[`SEL_NOAUTOMUX]) begin
      sdoOut_next = muxOut;
    end else begin
      sdoOut_next = lockLive;
    end
    sdoOe_next = serialFrameActive | outSelect_reg[`SEL_KEEPDRV];
  end

  // count is passed on only in variant mode; modulator does the math
  always @* begin
    if (variantMode) begin
      exactOut_next = exactChannels_reg;
      exactEnable_next = (exactChannels_reg >= `EXACT_MIN);
    end else begin
      exactOut_next = `EXACT_RST;
      exactEnable_next = 1'b0;
    end
  end

  // read data sampled live at the strobe and held until the next read
  always @* begin
    rdValid_next = rdStrobe;
    rdData_next = rdData_reg;
    if (rdStrobe) begin
      if (hit(regAddr, `OFF_EXACT_FREQ)) begin
        rdData_next = {{(`DATA_W-`EXACT_W){1'b0}}, exactChannels_reg};
      end else if (hit(regAddr, `OFF_OUT_SELECT)) begin
        rdData_next = {{(`DATA_W-`SEL_W){1'b0}}, outSelect_reg};
      end else if (hit(regAddr, `OFF_OUT_STATUS)) begin
        rdData_next = {`STATUS_PAD, lockLive, muxOut};
      end else if (hit(regAddr, `OFF_SELF_TEST)) begin
        rdData_next = {`TEST_PAD, selfTestRunning, selfTestSignature};
      end else begin
        rdData_next = `ZERO_DATA;
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdoOut_reg <= 1'b0;
      sdoOe_reg <= 1'b0;
      outputStatus_reg <= 1'b0;
      exactOut_reg <= `EXACT_RST;
      exactEnable_reg <= 1'b0;
      rdData_reg <= `ZERO_DATA;
      rdValid_reg <= 1'b0;
    end else begin
      sdoOut_reg <= sdoOut_next;
      sdoOe_reg <= sdoOe_next;
      outputStatus_reg <= outputStatus_next;
      exactOut_reg <= exactOut_next;
      exactEnable_reg <= exactEnable_next;
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

endmodule

// *** test/gpo_mux_status_regs_asserts.sv ***
/* port checker for gpo_mux_status_regs.
   assumes the bind below and the map header. */
`include "gpo_mux_status_map.vh"
module gpo_mux_status_regs_asserts (
  input wire clk, input wire rst_b, input wire rdStrobe, input wire rdValid,
  input wire [`ADDR_W-1:0] regAddr, input wire [`DATA_W-1:0] rdData,
  input wire variantMode, input wire serialFrameActive, input wire serialDataOut,
  input wire [`SIG_W-1:0] selfTestSignature, input wire selfTestRunning,
  input wire [`EXACT_W-1:0] exactChannels, input wire exactEnable, input wire sdoOut,
  input wire sdoOe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_exact_gate: assert property (exactEnable == (exactChannels >= 2)) else $error("gate");
  a_exact_idle: assert property (!variantMode |=> exactChannels == 0) else $error("idle");
  a_read_valid: assert property (rdStrobe |=> rdValid) else $error("valid");
  a_no_phantom: assert property (!rdStrobe |=> !rdValid) else $error("phantom");
  a_rsvd_zero: assert property (rdStrobe && regAddr[5:1] == 5'h08 |=> rdData == 0)
    else $error("rsvd");
  a_test_live: assert property (rdStrobe && regAddr == `OFF_SELF_TEST |=>
    rdData == {`TEST_PAD, $past(selfTestRunning), $past(selfTestSignature)}) else $error("test");
  a_status_pad: assert property (rdStrobe && regAddr == `OFF_OUT_STATUS |=>
    rdData[23:2] == `STATUS_PAD) else $error("pad");
  a_frame_drive: assert property (serialFrameActive |=>
    sdoOe && sdoOut == $past(serialDataOut)) else $error("frame");
  cover property (exactEnable);
  cover property (serialFrameActive);
  cover property (rdStrobe && regAddr == `OFF_SELF_TEST);
endmodule
bind gpo_mux_status_regs gpo_mux_status_regs_asserts chk (.clk, .rst_b, .rdStrobe, .rdValid,
  .regAddr, .rdData, .variantMode, .serialFrameActive, .serialDataOut, .selfTestSignature,
  .selfTestRunning, .exactChannels, .exactEnable, .sdoOut, .sdoOe);

// *** test/host_model.sv ***
/* serial host: one-cycle strobes at the falling edge.
   assumes the bench clock. */
`include "gpo_mux_status_map.vh"
module host_model (
  input wire clk,
  input wire [`DATA_W-1:0] rdData,
  input wire rdValid,
  output logic wrStrobe = 1'b0,
  output logic rdStrobe = 1'b0,
  output logic [`ADDR_W-1:0] regAddr = 6'h00,
  output logic [`DATA_W-1:0] wrData = 24'h00_0000
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] x);
    @(negedge clk);
    {wrStrobe, regAddr, wrData} = {1'b1, a, x};
    @(negedge clk);
    wrStrobe = 1'b0;
    // stale data never looks like a held value
    wrData = ~x;
  endtask
  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] x, output logic v);
    @(negedge clk);
    {rdStrobe, regAddr} = {1'b1, a};
    @(negedge clk);
    {x, v, rdStrobe} = {rdData, rdValid, 1'b0};
  endtask
endmodule

// *** test/testbench.sv ***
/* register, mux and status tests through the strobe port.
   assumes host_model and the checker bind. */
`include "gpo_mux_status_map.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, vm = 1'b0, fr = 1'b0, fd = 1'b0, bsy = 1'b1, v, e;
  logic [31:0] s = 32'h0000_0000;
  logic [15:0] sg = 16'ha5c3;
  logic [23:0] d;
  logic [13:0] cnt [4] = '{14'h0000, 14'h0001, 14'h0002, 14'h3fff};
  wire wrStrobe, rdStrobe, rdValid, sdoOut, sdoOe, outputStatus, exactEnable;
  wire [5:0] regAddr;
  wire [23:0] wrData, rdData;
  wire [13:0] exactChannels;
  int error_cnt = 0, n_compared = 0;
  always #10 clk = ~clk;
  host_model host (.clk, .rdData, .rdValid, .wrStrobe, .rdStrobe, .regAddr, .wrData);
  gpo_mux_status_regs dut (.clk, .rst_b, .wrStrobe, .rdStrobe, .regAddr, .wrData, .rdData,
    .rdValid, .variantMode(vm), .serialFrameActive(fr), .serialDataOut(fd), .lockIn(s[1]),
    .lockTrigger(s[2]), .lockWindow(s[3]), .ringOscIn(s[4]), .cycleSlipGuard(s[5]),
    .refBufferOut(s[8]), .refDividerOut(s[9]), .feedbackDividerOut(s[10]),
    .modulatorClock(s[11]), .auxClock(s[12]), .auxSerialClock(s[13]),
    .auxSerialEnable(s[14]), .auxSerialDataOut(s[15]), .phaseDownPulse(s[16]),
    .phaseUpPulse(s[17]), .modDelayedClock(s[18]), .modCoreClock(s[19]),
    .autoStrobeInt(s[20]), .autoStrobeFrac(s[21]), .autoStrobeAux(s[22]),
    .serialLatchEnable(s[23]), .dividerSyncReset(s[24]), .seedLoadStrobe(s[25]),
    .serialBufferEnable(s[30]), .softwareResetRequest(s[31]), .selfTestSignature(sg),
    .selfTestRunning(bsy), .exactChannels, .exactEnable, .sdoOut, .sdoOe, .outputStatus);
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic rc(input logic [5:0] a, input logic [23:0] x);
    host.rd(a, d, v);
    `CHK("rdData", {1'b1, x}, {v, d})
  endtask
  // sync stages on lock and ring inputs need the margin
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask
  initial begin
    #100us;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rc(`OFF_OUT_SELECT, 24'h00_0001);
    rc(`OFF_EXACT_FREQ, 24'h00_0000);
    for (int a = 16; a < 20; a++) host.wr(6'(a), 24'hff_ffff);
    rc(`OFF_RSVD_A, 24'h00_0000);
    rc(`OFF_RSVD_B, 24'h00_0000);
    rc(`OFF_SELF_TEST, {7'h00, bsy, sg});
    {bsy, sg} = {1'b0, 16'h1234};
    rc(`OFF_SELF_TEST, 24'h00_1234);
    vm = 1'b1;
    foreach (cnt[i]) begin
      host.wr(`OFF_EXACT_FREQ, {10'h000, cnt[i]});
      settle();
      `CHK("exactEnable", cnt[i] >= 2, exactEnable)
      `CHK("exactChannels", cnt[i], exactChannels)
    end
    vm = 1'b0;
    settle();
    `CHK("exactChannels", 14'h0000, exactChannels)
    `CHK("exactEnable", 1'b0, exactEnable)
    rc(`OFF_EXACT_FREQ, 24'h00_3fff);
    for (int c = 0; c < 32; c++) begin
      for (int b = 0; b < 2; b++) begin
        s = b ? 32'h0000_0001 << c : ~(32'h0000_0001 << c);
        host.wr(`OFF_OUT_SELECT, 24'(32'h0000_0040 | (b << 5) | c));
        settle();
        e = (c == 0) ? b[0] : (c == 6) ? s[5] : s[c];
        if (c == 7 || (c > 25 && c < 30)) e = 1'b0;
        `CHK("sdoOut", e, sdoOut)
        `CHK("outputStatus", e, outputStatus)
      end
    end
    s = 32'h0000_0002;
    host.wr(`OFF_OUT_SELECT, 24'h00_0042);
    settle();
    rc(`OFF_OUT_STATUS, 24'h00_0002);
    s = 32'h0000_0004;
    settle();
    rc(`OFF_OUT_STATUS, 24'h00_0001);
    s = 32'h0000_0002;
    host.wr(`OFF_OUT_SELECT, 24'h00_0002);
    settle();
    `CHK("sdoOut", 1'b1, sdoOut)
    `CHK("sdoOe", 1'b0, sdoOe)
    host.wr(`OFF_OUT_SELECT, 24'h00_0082);
    fr = 1'b1;
    settle();
    `CHK("sdoOut", 1'b0, sdoOut)
    `CHK("sdoOe", 1'b1, sdoOe)
    fr = 1'b0;
    settle();
    `CHK("sdoOe", 1'b1, sdoOe)
    tally_and_finish();
  end
endmodule
